// *** design/pfm_pkg.sv ***
// Package of constants and types for the pin function select mux
package pfm_pkg;
   localparam int SEL_W = 4;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] SEL_REG_OFFSET = 16'h0172;
   localparam logic [DATA_W-1:0] SEL_REG_RESET = 16'h0000;
   localparam int CARRIER_SEL_LSB = 8;
   localparam int COL_SEL_LSB = 4;
   localparam int RX_ERROR_SEL_LSB = 0;
   localparam int GEN1_SEL_LSB = 4;
   localparam int GEN0_SEL_LSB = 0;
   localparam int NUM_PINS = 3;
   localparam logic [SEL_W-1:0] SEL_NORMAL = 4'h0;
   localparam logic [SEL_W-1:0] SEL_TX_SFD = 4'h1;
   localparam logic [SEL_W-1:0] SEL_RX_SFD = 4'h2;
   localparam logic [SEL_W-1:0] SEL_WAKE = 4'h3;
   localparam logic [SEL_W-1:0] SEL_ENERGY = 4'h4;
   localparam logic [SEL_W-1:0] SEL_LED3 = 4'h6;
   localparam logic [SEL_W-1:0] SEL_PRBS = 4'h7;
   localparam logic [SEL_W-1:0] SEL_CONST0 = 4'h8;
   localparam logic [SEL_W-1:0] SEL_CONST1 = 4'h9;

   // Internal event sources shared by all pins except pin 2 of the small package, which stays low
   typedef struct packed {
      logic tx_sfd;
      logic rx_sfd;
      logic wake_packet_indication;
      logic energy_detect;
      logic third_led_signal;
      logic prbs_error;
   } pfm_src_t;

   // Normal MII functions available to the pins
   typedef struct packed {
      logic carrier_sense;
      logic collision;
      logic rx_error;
   } pfm_mii_t;
endpackage : pfm_pkg

// *** design/pfm_mux.sv ***
// Pin function select mux with its select register and register port
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module pfm_mux #(
   parameter bit SMALL_PKG = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [pfm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pfm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pfm_pkg::DATA_W-1:0] reg_rdata,
   input wire pfm_pkg::pfm_mii_t mii_in,
   input wire pfm_pkg::pfm_src_t src_in,
   output logic [pfm_pkg::NUM_PINS-1:0] pin_out
);
   import pfm_pkg::*;

   logic [DATA_W-1:0] sel_reg;
   logic [DATA_W-1:0] sel_next;
   logic [DATA_W-1:0] wmask;
   logic [SEL_W-1:0] pin_sel [NUM_PINS];
   logic [NUM_PINS-1:0] normal_src;
   logic [NUM_PINS-1:0] pin_next;

   // Writable bits depend on the package variant
   assign wmask = SMALL_PKG ? 16'h00FF : 16'h0FFF;
   assign sel_next = reg_wdata & wmask;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= SEL_REG_RESET;
      end else if (reg_wr && reg_addr == SEL_REG_OFFSET) begin
         sel_reg <= sel_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd && reg_addr == SEL_REG_OFFSET) begin
         reg_rdata <= sel_reg;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Pin 0 is rx error / general 0, pin 1 collision / general 1, pin 2 carrier
   always_comb begin
      pin_sel[0] = sel_reg[RX_ERROR_SEL_LSB +: SEL_W];
      pin_sel[1] = sel_reg[COL_SEL_LSB +: SEL_W];
      pin_sel[2] = SMALL_PKG ? SEL_NORMAL : sel_reg[CARRIER_SEL_LSB +: SEL_W];
      normal_src[0] = mii_in.rx_error;
      normal_src[1] = mii_in.collision;
      normal_src[2] = SMALL_PKG ? 1'b0 : mii_in.carrier_sense;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_comb begin
            case (pin_sel[gi])
               SEL_NORMAL: pin_next[gi] = normal_src[gi];
               SEL_TX_SFD: pin_next[gi] = src_in.tx_sfd;
               SEL_RX_SFD: pin_next[gi] = src_in.rx_sfd;
               SEL_WAKE: pin_next[gi] = src_in.wake_packet_indication;
               SEL_ENERGY: pin_next[gi] = src_in.energy_detect;
               SEL_LED3: pin_next[gi] = src_in.third_led_signal;
               SEL_PRBS: pin_next[gi] = src_in.prbs_error;
               SEL_CONST0: pin_next[gi] = 1'b0;
               SEL_CONST1: pin_next[gi] = 1'b1;
               // Reserved codes drive low
               default: pin_next[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
      end else begin
         pin_out <= pin_next;
      end
   end

   // Register port checks
   a_reserved_read: assert property (@(posedge clk) disable iff (!rst_n)
      $past(reg_rd) |-> (reg_rdata & ~wmask) == 16'h0000)
      else $error("reserved register bits read nonzero");

   a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == SEL_REG_OFFSET ##1 reg_rd && reg_addr == SEL_REG_OFFSET
      |=> reg_rdata == $past(sel_next, 2))
      else $error("select register read back mismatch");

   a_rdata_value: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == SEL_REG_OFFSET
      |=> reg_rdata == $past(sel_reg))
      else $error("read data not the register value");

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !(reg_rd && reg_addr == SEL_REG_OFFSET)
      |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");

   a_read_other_addr: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr != SEL_REG_OFFSET
      |=> reg_rdata == 16'h0000)
      else $error("read of another address not zero");

   a_rdata_reset: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> reg_rdata == 16'h0000)
      else $error("read data not zero after reset");

   a_reset_value: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> sel_reg == SEL_REG_RESET)
      else $error("select register not zero after reset");

   a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      sel_reg[15:12] == 4'h0)
      else $error("select register top bits not zero");

   a_small_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      SMALL_PKG
      |-> sel_reg[15:8] == 8'h00)
      else $error("small package upper byte not zero");

   a_small_carrier_zero: assert property (@(posedge clk) disable iff (!rst_n)
      SMALL_PKG && reg_wr && reg_addr == SEL_REG_OFFSET
      |=> sel_reg[11:8] == 4'h0)
      else $error("small package kept bits 11:8");

   a_low_fields_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == SEL_REG_OFFSET
      |=> sel_reg[7:0] == $past(reg_wdata[7:0]))
      else $error("low select fields not written");

   a_carrier_field_write: assert property (@(posedge clk) disable iff (!rst_n)
      !SMALL_PKG && reg_wr && reg_addr == SEL_REG_OFFSET
      |=> sel_reg[11:8] == $past(reg_wdata[11:8]))
      else $error("carrier select field not written");

   a_other_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr != SEL_REG_OFFSET
      |=> $stable(sel_reg))
      else $error("write to another address changed the register");

   a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_wr
      |=> $stable(sel_reg))
      else $error("select register changed without a write");

   // Routing checks on single pins
   a_rx_err_normal: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[0] == SEL_NORMAL |=> pin_out[0] == $past(mii_in.rx_error))
      else $error("rx error pin not normal function");

   a_col_normal: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[1] == SEL_NORMAL |=> pin_out[1] == $past(mii_in.collision))
      else $error("collision pin not normal function");

   a_carrier_normal: assert property (@(posedge clk) disable iff (!rst_n)
      !SMALL_PKG && pin_sel[2] == SEL_NORMAL
      |=> pin_out[2] == $past(mii_in.carrier_sense))
      else $error("carrier pin not normal function");

   a_tx_sfd_route: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[0] == SEL_TX_SFD |=> pin_out[0] == $past(src_in.tx_sfd))
      else $error("tx sfd not routed");

   a_rx_sfd_route: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[1] == SEL_RX_SFD |=> pin_out[1] == $past(src_in.rx_sfd))
      else $error("rx sfd not routed");

   a_wake_route: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[0] == SEL_WAKE |=> pin_out[0] == $past(src_in.wake_packet_indication))
      else $error("wake indication not routed");

   a_energy_route: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[1] == SEL_ENERGY |=> pin_out[1] == $past(src_in.energy_detect))
      else $error("energy detect not routed");

   a_led_prbs_route: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[0] == SEL_LED3 ##1 pin_sel[0] == SEL_PRBS
      |-> pin_out[0] == $past(src_in.third_led_signal)
      ##1 pin_out[0] == $past(src_in.prbs_error))
      else $error("led or prbs not routed");

   a_const_force: assert property (@(posedge clk) disable iff (!rst_n)
      pin_sel[1] == SEL_CONST1 |=> pin_out[1])
      else $error("constant high not forced");

   a_write_latency: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == SEL_REG_OFFSET && reg_wdata[3:0] == SEL_CONST0
      |=> ##1 !pin_out[0])
      else $error("new select late on pin");

   a_small_spare_low: assert property (@(posedge clk) disable iff (!rst_n)
      SMALL_PKG
      |-> !pin_out[2])
      else $error("small package spare pin not low");

   a_write_to_pin: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == SEL_REG_OFFSET && reg_wdata[GEN1_SEL_LSB +: SEL_W] == SEL_CONST1
      |=> ##1 pin_out[1])
      else $error("new select late on general pin");

   // Cycles since the last accepted write, saturating at three; zero means none yet
   logic [1:0] since_write;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         since_write <= 2'h0;
      end else if (reg_wr && reg_addr == SEL_REG_OFFSET) begin
         since_write <= 2'h1;
      end else if (since_write != 2'h0 && since_write != 2'h3) begin
         since_write <= since_write + 2'h1;
      end
   end

   a_latency_high: assert property (@(posedge clk) disable iff (!rst_n)
      since_write == 2'h2 && sel_reg[RX_ERROR_SEL_LSB +: SEL_W] == SEL_CONST1
      |-> pin_out[0])
      else $error("pin not high two cycles after write");

   a_latency_low: assert property (@(posedge clk) disable iff (!rst_n)
      since_write == 2'h2 && sel_reg[RX_ERROR_SEL_LSB +: SEL_W] == SEL_CONST0
      |-> !pin_out[0])
      else $error("pin not low two cycles after write");

   // Normal function each pin must show, per package layout
   logic [NUM_PINS-1:0] exp_normal;
   always_comb begin
      exp_normal[0] = mii_in.rx_error;
      exp_normal[1] = mii_in.collision;
      exp_normal[2] = mii_in.carrier_sense && !SMALL_PKG;
   end

   // Select field each pin must follow, per package layout
   logic [SEL_W-1:0] exp_sel [NUM_PINS];
   always_comb begin
      if (SMALL_PKG) begin
         exp_sel[0] = sel_reg[GEN0_SEL_LSB +: SEL_W];
         exp_sel[1] = sel_reg[GEN1_SEL_LSB +: SEL_W];
         exp_sel[2] = SEL_NORMAL;
      end else begin
         exp_sel[0] = sel_reg[RX_ERROR_SEL_LSB +: SEL_W];
         exp_sel[1] = sel_reg[COL_SEL_LSB +: SEL_W];
         exp_sel[2] = sel_reg[CARRIER_SEL_LSB +: SEL_W];
      end
   end

   // Every pin against the shared code table
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin_chk
         a_pin_select: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == exp_sel[gi])
            else $error("pin follows the wrong select field");

         a_pin_normal: assert property (@(posedge clk)
            disable iff (!rst_n) pin_sel[gi] == SEL_NORMAL
            |=> pin_out[gi] == $past(exp_normal[gi]))
            else $error("pin not showing its normal function");

         a_pin_tx_sfd: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_TX_SFD
            |=> pin_out[gi] == $past(src_in.tx_sfd))
            else $error("tx sfd not routed to pin");

         a_pin_rx_sfd: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_RX_SFD
            |=> pin_out[gi] == $past(src_in.rx_sfd))
            else $error("rx sfd not routed to pin");

         a_pin_wake: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_WAKE
            |=> pin_out[gi] == $past(src_in.wake_packet_indication))
            else $error("wake indication not routed to pin");

         a_pin_energy: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_ENERGY
            |=> pin_out[gi] == $past(src_in.energy_detect))
            else $error("energy detect not routed to pin");

         a_pin_led: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_LED3
            |=> pin_out[gi] == $past(src_in.third_led_signal))
            else $error("led signal not routed to pin");

         a_pin_prbs: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_PRBS
            |=> pin_out[gi] == $past(src_in.prbs_error))
            else $error("prbs indication not routed to pin");

         a_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_CONST0
            |=> !pin_out[gi])
            else $error("constant low not forced on pin");

         a_pin_high: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == SEL_CONST1
            |=> pin_out[gi])
            else $error("constant high not forced on pin");

         a_pin_reserved_five: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] == 4'h5
            |=> !pin_out[gi])
            else $error("reserved code five not driving low");

         a_pin_reserved_high: assert property (@(posedge clk) disable iff (!rst_n)
            pin_sel[gi] > SEL_CONST1
            |=> !pin_out[gi])
            else $error("reserved upper code not driving low");

         a_pin_reset_low: assert property (@(posedge clk) disable iff (!rst_n)
            $rose(rst_n)
            |-> !pin_out[gi])
            else $error("pin not low after reset");
      end
   endgenerate

   // Main scenarios
   c_write: cover property (@(posedge clk) reg_wr && reg_addr == SEL_REG_OFFSET);
   c_read: cover property (@(posedge clk) reg_rd && reg_addr == SEL_REG_OFFSET);
   c_pin_high: cover property (@(posedge clk) pin_sel[0] == SEL_CONST1 ##1 pin_out[0]);
   c_sfd_pulse: cover property (@(posedge clk) pin_sel[1] == SEL_TX_SFD && src_in.tx_sfd);
   c_latency: cover property (@(posedge clk) since_write == 2'h2);
endmodule : pfm_mux

// *** bench/pfm_pin_sampler.sv ***
// Far-side model that samples the repurposed pins each clock
`timescale 1ns/1ps
module pfm_pin_sampler #(
   parameter int W = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pins,
   output logic [W-1:0] seen
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= '0;
      end else begin
         seen <= pins;
      end
   end
endmodule : pfm_pin_sampler

// *** bench/phy_pin_function_select_mux_tb_top.sv ***
// Self-checking bench for the pin function select mux
`timescale 1ns/1ps
module phy_pin_function_select_mux_tb_top;
   import pfm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] rd_l, rd_s;
   pfm_mii_t mii_in = 3'h6;
   pfm_src_t src_in = '0;
   logic [NUM_PINS-1:0] pin_l, pin_s;
   logic [5:0] seen;
   int n_errors = 0;
   int total_checks = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   pfm_mux #(.SMALL_PKG(1'b0)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd_l),
      .mii_in(mii_in), .src_in(src_in), .pin_out(pin_l));
   pfm_mux #(.SMALL_PKG(1'b1)) i_dut_small (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rd_s),
      .mii_in(mii_in), .src_in(src_in), .pin_out(pin_s));
   pfm_pin_sampler #(.W(6)) i_far (.clk(clk), .rst_n(rst_n), .pins({pin_s, pin_l}),
      .seen(seen));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] el, input logic [15:0] es);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(rd_l, el);
      chk(rd_s, es);
   endtask : rd
   function automatic logic ep(input int c, input logic n, input logic [5:0] s);
      case (c)
         0: return n;
         1: return s[5];
         2: return s[4];
         3: return s[3];
         4: return s[2];
         6: return s[1];
         7: return s[0];
         9: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : ep
   // Expected {small pins, large pins} for code c under input pattern p
   function automatic logic [5:0] xp(input int c, input int p);
      logic [5:0] s;
      logic [2:0] m;
      s = 6'(1 << p);
      m = 3'(p);
      return {1'b0, ep(c, m[1], s), ep(c, m[0], s), ep(c, m[2], s), ep(c, m[1], s), ep(c, m[0], s)};
   endfunction : xp
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(SEL_REG_OFFSET, 16'h0000, 16'h0000);
      wr(SEL_REG_OFFSET, 16'hFFFF);
      rd(SEL_REG_OFFSET, 16'h0FFF, 16'h00FF);
      wr(16'h0171, 16'h0000);
      rd(16'h0171, 16'h0000, 16'h0000);
      rd(SEL_REG_OFFSET, 16'h0FFF, 16'h00FF);
      for (int c = 0; c < 10; c++) begin
         if (c == 5) continue;
         wr(SEL_REG_OFFSET, {4'h0, c[3:0], c[3:0], c[3:0]});
         @(posedge clk);
         #1;
         chk(16'(pin_l), 16'(xp(c, 6) & 6'h07));
         for (int p = 0; p < 7; p++) begin
            @(posedge clk);
            src_in <= pfm_src_t'(6'(1 << p));
            mii_in <= pfm_mii_t'(3'(p));
            repeat (3) @(posedge clk);
            #1;
            chk(16'(seen), 16'(xp(c, p)));
         end
      end
      end_of_test();
   end
endmodule : phy_pin_function_select_mux_tb_top
